// [rtl/flash_host_pkg.sv]
// constants for the boot-block flash erase host controller
package flash_host_pkg;
    // command codes written to the flash data bus
    localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
    localparam logic [7:0] CMD_CONFIRM       = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND       = 8'hB0;
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_PROGRAM       = 8'h40;
    // status bit positions
    localparam int SR_READY   = 7;
    localparam int SR_SUSP    = 6;
    localparam int SR_ERASE   = 5;
    localparam int SR_PROG    = 4;
    localparam int SR_VPP     = 3;
    // controller register offsets (plain port, 4-bit address)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_DATA   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_PULSE  = 4'h4;
    // control opcodes written to REG_CTRL
    localparam logic [2:0] OP_ERASE   = 3'h1;
    localparam logic [2:0] OP_SUSPEND = 3'h2;
    localparam logic [2:0] OP_RESUME  = 3'h3;
    localparam logic [2:0] OP_CLEAR   = 3'h4;
    localparam logic [2:0] OP_READ    = 3'h5;
    localparam logic [2:0] OP_PROGRAM = 3'h6;
    // timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int STROBE_MIN_NS     = 70;
    localparam int STROBE_CYCLES     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELOCK_NS         = 100;
    localparam int RELOCK_CYCLES     = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PULSE_RESET = 8'(STROBE_CYCLES);
    localparam logic [7:0] STATUS_RESET = 8'h80;
    // shortest strobe the two-flop read path can still sample
    localparam logic [7:0] PULSE_MIN = 8'h03;
endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end
endmodule

// [rtl/flash_erase_host.sv]
// host controller driving a boot-block flash erase/suspend/status sequence
//
// Contract
// - erase is setup 20h then D0h
// - toggle enable between successive status reads
// - errors persist; clear before next operation (the code refuses only erase and program while an error bit is set)
// - error check may follow whole sequence
// - B0h suspends erase, then poll ready
// - after FFh, read other blocks
// - D0h resumes erase, busy again
// - boot block needs unlock level or wp
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module flash_erase_host
    import flash_host_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic      [18:0] flash_addr,
    output logic      [7:0]  flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [7:0]  flash_dq_in,
    output logic             chip_enable_n,
    output logic             output_enable_n,
    output logic             write_enable_n,
    output logic             write_protect,
    output logic             powerdown_unlock_pin,
    output logic             unlock_high_level
);
    typedef enum {S_IDLE, S_WR_LOW, S_WR_GAP, S_RD_LOW, S_RD_GAP, S_DONE} state_t;
    typedef enum {K_NONE, K_ERASE, K_SUSP, K_RESUME, K_CLEAR, K_READ, K_PROG} kind_t;

    state_t      state, next_state;
    kind_t       kind, next_kind;
    logic [1:0]  step, next_step;
    logic [7:0]  cnt, next_cnt;
    logic [18:0] addr, next_addr;
    logic [7:0]  wdata, next_wdata;
    logic [7:0]  status, next_status;
    logic [7:0]  rdata, next_rdata;
    logic [7:0]  pulse, next_pulse;
    logic        busy, next_busy;
    logic        boot_unlock, next_boot_unlock;
    logic        wp, next_wp;
    logic        suspended, next_suspended;
    logic        cmd_err, next_cmd_err;
    logic        susp_req, next_susp_req;
    logic [7:0]  drive_byte;
    logic        wr_phase;
    logic [7:0]  dq_sync;
    logic        cmd_go;

    pin_sync #(.WIDTH(8)) u_dq_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (flash_dq_in),
        .sync    (dq_sync)
    );

    assign cmd_go = reg_write && (reg_addr == REG_CTRL) && !busy;

    // byte for the write phase being entered, so data moves with the strobe
    always_comb begin
        drive_byte = CMD_READ_ARRAY;
        case (next_kind)
            K_ERASE:  drive_byte = (next_step == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
            K_SUSP:   drive_byte = CMD_SUSPEND;
            K_RESUME: drive_byte = CMD_CONFIRM;
            K_CLEAR:  drive_byte = CMD_CLEAR_STATUS;
            K_READ:   drive_byte = CMD_READ_ARRAY;
            K_PROG:   drive_byte = (next_step == 2'd0) ? CMD_PROGRAM : wdata;
            default:  drive_byte = CMD_READ_ARRAY;
        endcase
    end

    // sequencer next-state
    always_comb begin
        next_state       = state;
        next_kind        = kind;
        next_step        = step;
        next_cnt         = cnt;
        next_addr        = addr;
        next_wdata       = wdata;
        next_status      = status;
        next_rdata       = rdata;
        next_pulse       = pulse;
        next_busy        = busy;
        next_boot_unlock = boot_unlock;
        next_wp          = wp;
        next_suspended   = suspended;
        next_cmd_err     = cmd_err;
        next_susp_req    = susp_req;
        wr_phase         = 1'b0;
        if (reg_write && reg_addr == REG_ADDR) begin
            next_addr = reg_wdata[18:0];
        end
        if (reg_write && reg_addr == REG_DATA) begin
            next_wdata = reg_wdata[7:0];
        end
        // strobe width is software-set; floor keeps synchronised reads valid
        if (reg_write && reg_addr == REG_PULSE) begin
            next_pulse = (reg_wdata[7:0] < PULSE_MIN) ? PULSE_MIN : reg_wdata[7:0];
        end
        // boot-block unlock pins follow software while idle
        if (reg_write && reg_addr == REG_STATUS && !busy) begin
            next_boot_unlock = reg_wdata[0];
            next_wp          = reg_wdata[1];
        end
        // suspend request taken while an erase is being polled
        if (reg_write && reg_addr == REG_CTRL && busy && reg_wdata[2:0] == OP_SUSPEND
                && (kind == K_ERASE || kind == K_RESUME)) begin
            next_susp_req = 1'b1;
        end
        case (state)
            S_IDLE: begin
                if (cmd_go) begin
                    // refusal flag stands until the next command
                    next_cmd_err = 1'b0;
                    next_step = 2'd0;
                    next_cnt  = pulse;
                    next_busy = 1'b1;
                    next_state = S_WR_LOW;
                    case (reg_wdata[2:0])
                        OP_ERASE:   next_kind = K_ERASE;
                        OP_SUSPEND: next_kind = K_SUSP;
                        OP_RESUME:  next_kind = K_RESUME;
                        OP_CLEAR:   next_kind = K_CLEAR;
                        OP_READ:    next_kind = K_READ;
                        OP_PROGRAM: next_kind = K_PROG;
                        default: begin
                            next_kind  = K_NONE;
                            next_busy  = 1'b0;
                            next_state = S_IDLE;
                        end
                    endcase
                    // while suspended only read-array or resume go out
                    if (suspended && reg_wdata[2:0] != OP_READ
                            && reg_wdata[2:0] != OP_RESUME) begin
                        next_busy    = 1'b0;
                        next_state   = S_IDLE;
                        next_cmd_err = 1'b1;
                    end
                    // errors must be cleared before a new erase or program
                    if ((reg_wdata[2:0] == OP_ERASE || reg_wdata[2:0] == OP_PROGRAM)
                            && (status[SR_VPP] || status[SR_PROG] || status[SR_ERASE])) begin
                        next_busy    = 1'b0;
                        next_state   = S_IDLE;
                        next_cmd_err = 1'b1;
                    end
                end
            end
            S_WR_LOW: begin
                wr_phase = 1'b1;
                if (cnt <= 8'd1) begin
                    next_cnt   = pulse;
                    next_state = S_WR_GAP;
                end else begin
                    next_cnt = cnt - 8'd1;
                end
            end
            S_WR_GAP: begin
                if (cnt <= 8'd1) begin
                    next_cnt = pulse;
                    if ((kind == K_ERASE || kind == K_PROG) && step == 2'd0) begin
                        // second write carries D0h for erase or the data byte for program, and the block address
                        next_step  = 2'd1;
                        next_state = S_WR_LOW;
                    end else if (kind == K_CLEAR) begin
                        next_status = STATUS_RESET;
                        next_state  = S_DONE;
                    end else begin
                        // device now returns status; read array returns data
                        next_state = S_RD_LOW;
                    end
                end else begin
                    next_cnt = cnt - 8'd1;
                end
            end
            S_RD_LOW: begin
                if (cnt <= 8'd1) begin
                    next_cnt   = pulse;
                    next_rdata = dq_sync;
                    next_state = S_RD_GAP;
                end else begin
                    next_cnt = cnt - 8'd1;
                end
            end
            S_RD_GAP: begin
                // enables go high between polls so status refreshes
                if (cnt <= 8'd1) begin
                    next_cnt = pulse;
                    if (kind == K_READ) begin
                        next_state = S_DONE;
                    // poll until bit 7 reads one; no timeout, erase may take 17 s
                    end else if (!rdata[SR_READY] && susp_req) begin
                        // B0h goes out between two polls of the running erase
                        next_kind     = K_SUSP;
                        next_step     = 2'd0;
                        next_susp_req = 1'b0;
                        next_state    = S_WR_LOW;
                    end else if (!rdata[SR_READY]) begin
                        next_state = S_RD_LOW;
                    end else begin
                        next_status = {rdata[7:6], status[5:3] | rdata[5:3], rdata[2:0]};
                        if (kind == K_SUSP) begin
                            next_suspended = rdata[SR_SUSP];
                        end else if (kind == K_RESUME || kind == K_ERASE) begin
                            next_suspended = 1'b0;
                        end
                        next_state = S_DONE;
                    end
                end else begin
                    next_cnt = cnt - 8'd1;
                end
            end
            S_DONE: begin
                // a suspend that lost the race to completion is dropped
                next_susp_req = 1'b0;
                next_busy  = 1'b0;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    // reset returns the controller to idle, array read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= S_IDLE;
            kind        <= K_NONE;
            step        <= 2'd0;
            cnt         <= 8'h00;
            addr        <= '0;
            wdata       <= 8'hFF;
            status      <= STATUS_RESET;
            rdata       <= 8'hFF;
            pulse       <= PULSE_RESET;
            busy        <= 1'b0;
            boot_unlock <= 1'b0;
            wp          <= 1'b0;
            suspended   <= 1'b0;
            cmd_err     <= 1'b0;
            susp_req    <= 1'b0;
        end else begin
            state       <= next_state;
            kind        <= next_kind;
            step        <= next_step;
            cnt         <= next_cnt;
            addr        <= next_addr;
            wdata       <= next_wdata;
            status      <= next_status;
            rdata       <= next_rdata;
            pulse       <= next_pulse;
            busy        <= next_busy;
            boot_unlock <= next_boot_unlock;
            wp          <= next_wp;
            suspended   <= next_suspended;
            cmd_err     <= next_cmd_err;
            susp_req    <= next_susp_req;
        end
    end

    // pin drivers registered to keep strobes glitch free
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_enable_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
            flash_dq_oe     <= 1'b0;
            flash_dq_out    <= 8'hFF;
            flash_addr      <= '0;
        end else begin
            chip_enable_n   <= !(next_state == S_WR_LOW || next_state == S_RD_LOW);
            output_enable_n <= !(next_state == S_RD_LOW);
            write_enable_n  <= !(next_state == S_WR_LOW);
            flash_dq_oe     <= (next_state == S_WR_LOW || next_state == S_WR_GAP);
            flash_dq_out    <= drive_byte;
            flash_addr      <= next_addr;
        end
    end

    // relock follows the register within one cycle, well inside 100 ns
    assign powerdown_unlock_pin = 1'b1;
    assign unlock_high_level    = boot_unlock;
    assign write_protect        = wp;

    // register read port, data one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CTRL:   reg_rdata <= {28'h0, cmd_err, suspended, 1'b0, busy};
                REG_ADDR:   reg_rdata <= {13'h0, addr};
                REG_DATA:   reg_rdata <= {24'h0, rdata};
                REG_STATUS: reg_rdata <= {22'h0, wp, boot_unlock, status};
                REG_PULSE:  reg_rdata <= {24'h0, pulse};
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    chk_relock_prompt: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_write && reg_addr == REG_STATUS && !busy && !reg_wdata[0])
        |=> !unlock_high_level) else $error("boot block not relocked");

    sequence erase_setup_s;
        kind == K_ERASE && $rose(step[0]);
    endsequence
    chk_erase_order: assert property (@(posedge clk) disable iff (!reset_n)
        erase_setup_s |-> $past(flash_dq_out) == CMD_ERASE_SETUP
        && flash_dq_out == CMD_CONFIRM)
        else $error("erase confirm without setup");

    chk_strobe_gap: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(output_enable_n) |-> $past(output_enable_n, 2))
        else $error("status reads not separated");

    chk_suspend_guard: assert property (@(posedge clk) disable iff (!reset_n)
        (suspended && state == S_IDLE && cmd_go && reg_wdata[2:0] == OP_CLEAR)
        |=> state == S_IDLE && cmd_err) else $error("command sent while suspended");

    chk_error_block: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_IDLE && cmd_go && reg_wdata[2:0] == OP_ERASE
        && (status[SR_VPP] || status[SR_PROG] || status[SR_ERASE]))
        |=> !busy) else $error("erase started with error pending");

    chk_busy_poll: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_RD_GAP && cnt <= 8'd1 && kind != K_READ && !rdata[SR_READY]
        && !susp_req)
        |=> state == S_RD_LOW) else $error("busy status not repolled");

    chk_error_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        (status[SR_VPP] && kind != K_CLEAR) |=> status[SR_VPP])
        else $error("supply low flag lost");

    chk_pulse_min: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(write_enable_n) |-> ##1 !write_enable_n)
        else $error("write strobe shorter than two cycles");
endmodule

// [bench/flash_model.sv]
// behavioural boot-block flash answering the host controller's pins
module flash_model #(
    parameter int ERASE_CYC = 300,
    parameter int PROG_CYC  = 40
) (
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  dq_wr,
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        write_protect,
    input  wire logic        powerdown_unlock_pin,
    input  wire logic        unlock_high_level,
    input  wire logic        program_supply_low,
    output logic      [7:0]  dq_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  mem [int];
    logic [7:0]  sr = 8'h00;
    logic [7:0]  q = 8'h5A;
    logic [7:0]  cmd_d;
    logic [18:0] cmd_a;
    logic        status_mode = 1'b0;
    logic        erase_pend = 1'b0;
    logic        prog_pend = 1'b0;
    logic        susp = 1'b0;
    int          left = 0;
    int          keys[$];
    wire         wr_act = !chip_enable_n && !write_enable_n;
    wire         rd_act = !chip_enable_n && !output_enable_n;
    // protection follows the pins at once, so relock is immediate
    wire         unlocked = unlock_high_level || write_protect;
    assign dq_rd = q;

    function automatic logic [18:0] blk(input logic [18:0] a);
        if (a >= 19'h7C000) return 19'h7C000;
        if (a >= 19'h7A000) return 19'h7A000;
        if (a >= 19'h78000) return 19'h78000;
        if (a >= 19'h60000) return 19'h60000;
        return {a[18:17], 17'h0};
    endfunction

    initial forever begin
        #10;
        if (left > 0 && !susp) left--;
    end

    // power-down pin returns the interface to array reads
    always @(negedge powerdown_unlock_pin) status_mode = 1'b0;

    // data is latched once the strobe has settled
    always @(posedge wr_act) begin
        #1;
        cmd_d = dq_wr;
        cmd_a = addr;
    end

    always @(negedge wr_act) begin
        if (susp && cmd_d != 8'hFF && cmd_d != 8'hD0) begin
            status_mode = 1'b1;
        end else if (prog_pend) begin
            prog_pend = 1'b0;
            status_mode = 1'b1;
            if (program_supply_low) sr[3] = 1'b1;
            else if (blk(cmd_a) == 19'h7C000 && !unlocked) sr[4] = 1'b1;
            else begin
                mem[cmd_a] = cmd_d & (mem.exists(cmd_a) ? mem[cmd_a] : 8'hFF);
                left = PROG_CYC;
            end
        end else if (erase_pend) begin
            erase_pend = 1'b0;
            status_mode = 1'b1;
            if (cmd_d != 8'hD0) sr[5:4] = 2'b11;
            else if (program_supply_low) sr[3] = 1'b1;
            else if (blk(cmd_a) == 19'h7C000 && !unlocked) sr[5] = 1'b1;
            else begin
                keys.delete();
                foreach (mem[i]) if (blk(19'(i)) == blk(cmd_a)) keys.push_back(i);
                foreach (keys[k]) mem.delete(keys[k]);
                left = ERASE_CYC;
            end
        end else begin
            case (cmd_d)
                8'h20: begin
                    erase_pend = 1'b1;
                    status_mode = 1'b1;
                end
                8'h40: prog_pend = 1'b1;
                8'hD0: if (susp) begin
                    susp = 1'b0;
                    status_mode = 1'b1;
                end
                8'hB0: begin
                    status_mode = 1'b1;
                    susp = (left > 0);
                end
                8'h50: sr = 8'h00;
                8'h70: status_mode = 1'b1;
                8'hFF: status_mode = 1'b0;
                default: ;
            endcase
        end
    end

    // each read strobe takes a fresh snapshot; erased bytes read FFh
    always @(posedge rd_act) begin
        #1;
        if (status_mode) q = {left == 0 || susp, susp, sr[5:3], 3'b000};
        else q = mem.exists(addr) ? mem[addr] : 8'hFF;
    end

    // released bus shows the inverse, never a stale value
    always @(negedge rd_act) q = ~q;
endmodule

// [bench/flash_erase_host_test.sv]
// self-checking bench for the flash erase host controller
module flash_erase_host_test
    import flash_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        supply_low = 1'b0;
    logic [31:0] reg_rdata;
    logic [18:0] flash_addr;
    logic [7:0]  flash_dq_out;
    logic [7:0]  model_q;
    logic        flash_dq_oe;
    logic        chip_enable_n;
    logic        output_enable_n;
    logic        write_enable_n;
    logic        write_protect;
    logic        powerdown_unlock_pin;
    logic        unlock_high_level;
    logic [31:0] v;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          we_low = 0;
    int          pulse_exp = int'(PULSE_RESET);
    // shared data wire: the controller wins while it drives
    wire  [7:0]  dq_bus = flash_dq_oe ? flash_dq_out : model_q;

    flash_erase_host dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(dq_bus), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .write_protect(write_protect), .powerdown_unlock_pin(powerdown_unlock_pin),
        .unlock_high_level(unlock_high_level));

    flash_model flash (.addr(flash_addr), .dq_wr(dq_bus), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .write_protect(write_protect), .powerdown_unlock_pin(powerdown_unlock_pin),
        .unlock_high_level(unlock_high_level), .program_supply_low(supply_low),
        .dq_rd(model_q));

    initial forever #5 clk = ~clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // issue an opcode, then poll busy with a bounded count
    task automatic run(input logic [2:0] op);
        wr(REG_CTRL, {29'h0, op});
        for (int n = 0; n < 4000; n++) begin
            rd(REG_CTRL);
            if (v[0] === 1'b0) return;
        end
        check(v, 32'h0);
    endtask

    // watchdog plus write strobe width monitor, sampled where strobes are settled
    always @(negedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            final_report();
        end
        if (write_enable_n === 1'b0) we_low <= we_low + 1;
        else if (we_low != 0) begin
            check(32'(we_low), 32'(pulse_exp));
            we_low <= 0;
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        // reset defaults and erased array
        rd(REG_STATUS);
        check(v, 32'h80);
        rd(REG_CTRL);
        check(v, 32'h0);
        rd(REG_PULSE);
        check(v, 32'(PULSE_RESET));
        check({31'h0, powerdown_unlock_pin}, 32'h1);
        wr(REG_ADDR, 32'h5);
        run(OP_READ);
        rd(REG_DATA);
        check(v, 32'hFF);
        $display("test defaults done");
        // program with short strobes, then erase the block back
        wr(REG_PULSE, 32'h3);
        pulse_exp = 3;
        wr(REG_DATA, 32'hA5);
        run(OP_PROGRAM);
        rd(REG_STATUS);
        check(v, 32'h80);
        run(OP_READ);
        rd(REG_DATA);
        check(v, 32'hA5);
        run(OP_ERASE);
        rd(REG_STATUS);
        check(v, 32'h80);
        run(OP_READ);
        rd(REG_DATA);
        check(v, 32'hFF);
        $display("test program erase done");
        // suspend after the erase already finished
        run(OP_SUSPEND);
        rd(REG_STATUS);
        check(v, 32'h80);
        rd(REG_CTRL);
        check(v, 32'h0);
        $display("test suspend done");
        // real suspend of a running main-block erase, read elsewhere, resume
        wr(REG_ADDR, 32'h20000);
        wr(REG_CTRL, {29'h0, OP_ERASE});
        repeat (40) @(posedge clk);
        run(OP_SUSPEND);
        check(v, 32'h4);
        rd(REG_STATUS);
        check(v, 32'hC0);
        run(OP_CLEAR);
        check(v, 32'hC);
        wr(REG_ADDR, 32'h5);
        run(OP_READ);
        check(v, 32'h4);
        rd(REG_DATA);
        check(v, 32'hFF);
        wr(REG_ADDR, 32'h20000);
        run(OP_RESUME);
        check(v, 32'h0);
        rd(REG_STATUS);
        check(v, 32'h80);
        $display("test suspend resume done");
        // low supply error sticks and blocks until cleared
        supply_low = 1'b1;
        wr(REG_DATA, 32'h3C);
        run(OP_PROGRAM);
        rd(REG_STATUS);
        check(v, 32'h88);
        supply_low = 1'b0;
        run(OP_ERASE);
        check(v, 32'h8);
        rd(REG_STATUS);
        check(v, 32'h88);
        run(OP_CLEAR);
        rd(REG_STATUS);
        check(v, 32'h80);
        rd(REG_CTRL);
        check(v, 32'h0);
        $display("test errors done");
        // boot block locked, then unlocked, then relocked
        wr(REG_ADDR, 32'h7C010);
        run(OP_ERASE);
        rd(REG_STATUS);
        check(v, 32'hA0);
        run(OP_CLEAR);
        wr(REG_STATUS, 32'h1);
        check({31'h0, unlock_high_level}, 32'h1);
        run(OP_ERASE);
        rd(REG_STATUS);
        check(v, 32'h180);
        wr(REG_STATUS, 32'h0);
        check({31'h0, unlock_high_level}, 32'h0);
        $display("test boot block done");
        final_report();
    end
endmodule
